// ==== verilog/astm_pkg.sv ====
// constants and state encodings shared by both ends of the adc serial link
package astm_pkg;
  // word layout on the link
  localparam int WORD_BITS = 32;
  localparam int CTRL_BITS = 16;
  localparam int CHAN_EDGE = 8;
  localparam int CFG_EDGE = 16;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  // device oscillator timing
  localparam int OSC_PERIOD_NS = 80;
  localparam int POR_TIME_MS = 4;
  localparam int POR_CYC_DFLT = POR_TIME_MS * 1000000 / OSC_PERIOD_NS;
  localparam int TEST_WIN_X10 = 36;
  localparam int TEST_WIN_CYC = (TEST_WIN_X10 + 9) / 10;
  localparam int SCK_HALF_CYC = 8;
  localparam int SLEEP_MIN_CYC = SCK_HALF_CYC;
  localparam int CONV_CYC_DFLT = 200;
  // host timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int HOST_SCK_HALF_NS = 800;
  localparam int HOST_HALF_CYC = HOST_SCK_HALF_NS / CLK_PERIOD_NS;
  // device sequencing states
  typedef enum logic [4:0]
  {
    D_POR = 5'h01,
    D_CONV = 5'h02,
    D_SLEEP = 5'h04,
    D_WAIT = 5'h08,
    D_XFER = 5'h10
  } astm_dstate_t;
  // host sequencing states
  typedef enum logic [3:0]
  {
    H_IDLE = 4'h1,
    H_EOC = 4'h2,
    H_EXT = 4'h4,
    H_INT = 4'h8
  } astm_hstate_t;
endpackage

// ==== verilog/astm_link_if.sv ====
// four-wire link between the converter and its host, with pin resolution
`timescale 1ns/10ps
interface astm_link_if;
  logic cs_n;
  logic sdi;
  logic sck_host;
  logic sck_host_oe_n;
  logic sck_dev;
  logic sck_dev_oe_n;
  logic sdo_dev;
  logic sdo_oe_n;
  logic sck;
  logic sdo;
  // weak pull-up on the clock pin when nobody drives it
  assign sck = !sck_dev_oe_n ? sck_dev : (!sck_host_oe_n ? sck_host : 1'h1);
  // undriven data line reads high
  assign sdo = !sdo_oe_n ? sdo_dev : 1'h1;
  modport dev (
    input cs_n, sdi, sck,
    output sck_dev, sck_dev_oe_n, sdo_dev, sdo_oe_n
  );
  modport host (
    input sck, sdo,
    output cs_n, sdi, sck_host, sck_host_oe_n
  );
endinterface

// ==== verilog/astm_sync3.sv ====
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module astm_sync3
  import astm_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // pin and clean level
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } astm_sync_t;
  astm_sync_t sync_reg;
  astm_sync_t sync_next;
  // only the second stage looks at the first
  always_comb
  begin
    sync_next.s1 = pin_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    sync_next.q = (sync_reg.s2 == sync_reg.s3) ? sync_reg.s3 : sync_reg.q;
  end
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      sync_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    else
      sync_reg <= sync_next;
  end
  assign level_out = sync_reg.q;
endmodule

// ==== verilog/astm_dev.sv ====
// converter end of the link: clock-mode pick, conversion cycle and 32-bit exchange
// Function
// RQ1: host keeps chip select low in 3-wire mode
// RQ2: clock source latched at power-on reset end
// RQ3: power-on reset ends about 4 ms later
// RQ4: done flag on data out while selected
// RQ5: result loaded into shifter on flag fall
// RQ6: external mode: out on fall, in rise
// RQ7: 32nd external fall starts conversion, output high
// RQ8: floating or high clock selects internal mode
// RQ9: data out released while select is high
// RQ10: select fall drives clock low, shows flag
// RQ11: select rise inside window returns to sleep
// RQ12: after window device makes clock pulses
// RQ13: after 32nd rise convert, hold clock high
// RQ14: select rise mid-transfer starts new conversion
// RQ15: abort before 8th fall keeps old channel
// RQ16: configuration needs abort after 16th fall
// RQ17: pull-up during reset picks internal clock
// RQ18: continuous: both high converting, low sleeping
// RQ19: sleep half clock period, then transfer
// RQ20: continuous: in on rise, out fall
// RQ21: new settings apply to next conversion
// RQ22: host samples output on rising edges
// RQ23: conversion time is a cycle count
`timescale 1ns/10ps
module astm_dev
  import astm_pkg::*;
#(
  parameter int POR_CYC = POR_CYC_DFLT,
  parameter int CONV_CYC = CONV_CYC_DFLT
)(
  // oscillator clock and reset
  input wire logic osc_clk_in,
  input wire logic srst_in,
  // serial link
  astm_link_if.dev link,
  // converter core side
  input wire logic [31:0] conv_result_in,
  output logic conv_start_out,
  output logic eoc_n_out,
  output logic ext_mode_out,
  output logic [7:0] chan_out,
  output logic [7:0] cfg_out
);
  typedef struct packed
  {
    astm_dstate_t st;
    logic ext;
    logic [15:0] cnt;
    logic [5:0] rises;
    logic [5:0] falls;
    logic sck_drv;
    logic sck_prev;
    logic cs_prev;
    logic [31:0] shreg;
    logic [6:0] in_sr;
    logic [7:0] pend_chan;
    logic [7:0] pend_cfg;
    logic [7:0] chan;
    logic [7:0] cfg;
    logic start;
  } astm_dreg_t;

  astm_dreg_t state_reg;
  astm_dreg_t state_next;
  logic cs_s;
  logic sck_s;
  logic sdi_s;

  // pins arrive from the host domain
  astm_sync3 #(.RST_VAL(1'h1)) u_cs (
    .clk_in(osc_clk_in),
    .srst_in(srst_in),
    .pin_in(link.cs_n),
    .level_out(cs_s)
  );
  astm_sync3 #(.RST_VAL(1'h1)) u_sck (
    .clk_in(osc_clk_in),
    .srst_in(srst_in),
    .pin_in(link.sck),
    .level_out(sck_s)
  );
  astm_sync3 #(.RST_VAL(1'h0)) u_sdi (
    .clk_in(osc_clk_in),
    .srst_in(srst_in),
    .pin_in(link.sdi),
    .level_out(sdi_s)
  );

  // sequencing of reset, conversion, sleep, status window and transfer
  always_comb
  begin
    logic do_rise;
    logic do_fall;
    logic do_conv;
    logic ext_rise;
    logic ext_fall;
    logic cs_fall;
    logic cs_rise;
    do_rise = 1'h0;
    do_fall = 1'h0;
    do_conv = 1'h0;
    ext_rise = sck_s & ~state_reg.sck_prev;
    ext_fall = ~sck_s & state_reg.sck_prev;
    cs_fall = state_reg.cs_prev & ~cs_s;
    cs_rise = ~state_reg.cs_prev & cs_s;
    state_next = state_reg;
    state_next.start = 1'h0;
    state_next.sck_prev = sck_s;
    state_next.cs_prev = cs_s;
    unique case (state_reg.st)
      D_POR:
      begin
        state_next.cnt = state_reg.cnt + 16'h1; // see RQ3
        if (state_reg.cnt == 16'(POR_CYC - 1))
        begin
          // pin still pulled up unless the host holds it low
          state_next.ext = ~sck_s; // see RQ2 // see RQ17
          do_conv = 1'h1;
        end
      end
      D_CONV:
      begin
        state_next.cnt = state_reg.cnt + 16'h1; // see RQ23
        if (state_reg.cnt == 16'(CONV_CYC - 1))
        begin
          // the leading bit of the word is the done flag itself
          state_next.shreg = {1'h0, conv_result_in[30:0]}; // see RQ5
          state_next.st = D_SLEEP;
          if (!state_reg.ext && !cs_s)
          begin
            state_next.st = D_WAIT; // see RQ18
            state_next.cnt = 16'(SLEEP_MIN_CYC - 1); // see RQ19
          end
        end
      end
      D_SLEEP:
      begin
        if (state_reg.ext && !cs_s && ext_rise)
        begin
          state_next.st = D_XFER;
          do_rise = 1'h1; // see RQ6
        end
      end
      D_WAIT:
      begin
        state_next.cnt = state_reg.cnt - 16'h1;
        if (cs_s)
          state_next.st = D_SLEEP; // see RQ11
        else if (state_reg.cnt == 16'h0)
        begin
          // first internal rising edge also takes an input bit
          state_next.st = D_XFER; // see RQ12
          state_next.sck_drv = 1'h1;
          state_next.cnt = 16'h0;
          do_rise = 1'h1; // see RQ20
        end
      end
      D_XFER:
      begin
        if (state_reg.ext)
        begin
          do_rise = ext_rise; // see RQ6
          do_fall = ext_fall;
          if (ext_fall && state_reg.falls == 6'(WORD_BITS - 1))
            do_conv = 1'h1; // see RQ7
        end
        else
        begin
          state_next.cnt = state_reg.cnt + 16'h1;
          if (state_reg.cnt == 16'(SCK_HALF_CYC - 1))
          begin
            state_next.cnt = 16'h0;
            state_next.sck_drv = ~state_reg.sck_drv; // see RQ12
            do_fall = state_reg.sck_drv;
            do_rise = ~state_reg.sck_drv;
            // last bit must stand through the closing rise, so convert half a period later
            if (state_reg.sck_drv && state_reg.rises == 6'(WORD_BITS))
              do_conv = 1'h1; // see RQ13 // see RQ20
          end
        end
        if (cs_rise)
          do_conv = 1'h1; // see RQ14
      end
      default:
      begin
        state_next.st = D_POR;
      end
    endcase
    // mode is picked again on every select fall after power-on reset, pull-up still on then
    if (cs_fall && state_reg.st != D_POR)
    begin
      state_next.ext = ~sck_s; // see RQ8
      if (state_reg.st == D_SLEEP && sck_s)
      begin
        state_next.st = D_WAIT; // see RQ10
        state_next.cnt = 16'(TEST_WIN_CYC - 1); // see RQ11
      end
    end
    // input bits in on rising edges, channel and config staged
    if (do_rise)
    begin
      state_next.in_sr = {state_reg.in_sr[5:0], sdi_s};
      state_next.rises = state_reg.rises + 6'h1;
      if (state_reg.rises == 6'(CHAN_EDGE - 1))
        state_next.pend_chan = {state_reg.in_sr, sdi_s};
      if (state_reg.rises == 6'(CFG_EDGE - 1))
        state_next.pend_cfg = {state_reg.in_sr, sdi_s};
    end
    // output bits advance on falling edges
    if (do_fall)
    begin
      state_next.shreg = {state_reg.shreg[30:0], 1'h1}; // see RQ6
      state_next.falls = state_reg.falls + 6'h1;
    end
    // staged settings only reach the conversion now starting
    if (do_conv)
    begin
      if (state_next.falls >= 6'(CHAN_EDGE))
        state_next.chan = state_next.pend_chan; // see RQ15 // see RQ21
      if (state_next.falls >= 6'(CFG_EDGE))
        state_next.cfg = state_next.pend_cfg; // see RQ16
      state_next.st = D_CONV;
      state_next.cnt = 16'h0;
      state_next.rises = 6'h0;
      state_next.falls = 6'h0;
      state_next.start = 1'h1;
    end
  end

  // state register
  always_ff @(posedge osc_clk_in)
  begin
    if (srst_in)
    begin
      state_reg <= '0;
      state_reg.st <= D_POR;
      state_reg.sck_prev <= 1'h1;
      state_reg.cs_prev <= 1'h1;
      state_reg.shreg <= 32'hFFFFFFFF;
      state_reg.chan <= CHAN_RST;
      state_reg.cfg <= CFG_RST;
    end
    else
      state_reg <= state_next;
  end

  // pin drive: clock only in internal mode while selected
  assign link.sck_dev_oe_n = state_reg.ext | cs_s | (state_reg.st == D_POR); // see RQ10
  assign link.sck_dev = (state_reg.st == D_CONV) | // see RQ13 // see RQ18
                        ((state_reg.st == D_XFER) & state_reg.sck_drv);
  assign link.sdo_oe_n = cs_s; // see RQ9
  // flag high while converting, then the shifter's leading bit
  assign link.sdo_dev = (state_reg.st == D_CONV) | state_reg.shreg[31]; // see RQ4
  // core side
  assign conv_start_out = state_reg.start;
  assign eoc_n_out = (state_reg.st == D_CONV) | (state_reg.st == D_POR);
  assign ext_mode_out = state_reg.ext;
  assign chan_out = state_reg.chan;
  assign cfg_out = state_reg.cfg;
endmodule

// ==== verilog/astm_host.sv ====
// host end of the link: reads a 32-bit result while writing channel and config
`timescale 1ns/10ps
module astm_host
  import astm_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // serial link
  astm_link_if.host link,
  // user side
  input wire logic ext_mode_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [7:0] chan_in,
  input wire logic [7:0] cfg_in,
  output logic busy_out,
  output logic result_valid_out,
  output logic [31:0] result_out
);
  typedef struct packed
  {
    astm_hstate_t st;
    logic cs_n;
    logic sck;
    logic sck_prev;
    logic [4:0] cnt;
    logic [5:0] bits;
    logic [15:0] tx;
    logic [31:0] rx;
    logic [31:0] result;
    logic valid;
  } astm_hreg_t;

  astm_hreg_t state_reg;
  astm_hreg_t state_next;
  logic sck_s;
  logic sdo_s;

  // link pins come from the oscillator domain
  astm_sync3 #(.RST_VAL(1'h1)) u_sck (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .pin_in(link.sck),
    .level_out(sck_s)
  );
  astm_sync3 #(.RST_VAL(1'h1)) u_sdo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .pin_in(link.sdo),
    .level_out(sdo_s)
  );

  // read sequencing for both clock sources
  always_comb
  begin
    state_next = state_reg;
    state_next.valid = 1'h0;
    state_next.sck_prev = sck_s;
    unique case (state_reg.st)
      H_IDLE:
      begin
        if (start_in)
        begin
          state_next.tx = {chan_in, cfg_in};
          state_next.bits = 6'h0;
          state_next.cnt = 5'h0;
          state_next.st = ext_mode_in ? H_EOC : H_INT;
          state_next.cs_n = ext_mode_in;
        end
      end
      H_EOC:
      begin
        if (!sdo_s)
          state_next.st = H_EXT;
      end
      H_EXT:
      begin
        // host-made clock from a divider of clk_in
        state_next.cnt = state_reg.cnt + 5'h1;
        if (state_reg.cnt == 5'(HOST_HALF_CYC - 1))
        begin
          state_next.cnt = 5'h0;
          state_next.sck = ~state_reg.sck;
          if (!state_reg.sck)
          begin
            state_next.rx = {state_reg.rx[30:0], sdo_s}; // see RQ22
            state_next.bits = state_reg.bits + 6'h1;
          end
          else
          begin
            state_next.tx = {state_reg.tx[14:0], 1'h0}; // see RQ6
            if (state_reg.bits == 6'(WORD_BITS))
            begin
              state_next.result = state_reg.rx;
              state_next.valid = 1'h1;
              state_next.st = H_IDLE;
            end
          end
        end
      end
      H_INT:
      begin
        // the first fall is the device pulling the clock low, not a bit
        if (!sck_s && state_reg.sck_prev && state_reg.bits != 6'h0)
          state_next.tx = {state_reg.tx[14:0], 1'h0};
        if (sck_s && !state_reg.sck_prev)
        begin
          state_next.rx = {state_reg.rx[30:0], sdo_s}; // see RQ22
          state_next.bits = state_reg.bits + 6'h1;
          if (state_reg.bits == 6'(WORD_BITS - 1))
          begin
            state_next.result = {state_reg.rx[30:0], sdo_s};
            state_next.valid = 1'h1;
            state_next.cs_n = 1'h1;
            state_next.st = H_IDLE;
          end
        end
        if (abort_in)
        begin
          state_next.cs_n = 1'h1; // see RQ14
          state_next.st = H_IDLE;
        end
      end
      default:
      begin
        state_next.st = H_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state_reg <= '0;
      state_reg.st <= H_IDLE;
      state_reg.cs_n <= 1'h1;
      state_reg.sck_prev <= 1'h1;
    end
    else
      state_reg <= state_next;
  end

  // select tied low in external mode; clock held low from reset on
  assign link.cs_n = state_reg.cs_n & ~ext_mode_in; // see RQ1
  assign link.sck_host = state_reg.sck;
  assign link.sck_host_oe_n = ~ext_mode_in; // see RQ2
  assign link.sdi = state_reg.tx[15];
  assign busy_out = (state_reg.st != H_IDLE);
  assign result_valid_out = state_reg.valid;
  assign result_out = state_reg.result;
endmodule

// ==== testbench/astm_link_monitor.sv ====
// concurrent checks on the converter link, sampled on the link clock
`timescale 1ns/10ps
module astm_link_monitor
  import astm_pkg::*;
(
  // link clock and reset
  input wire logic osc_clk_in,
  input wire logic srst_in,
  // link pins
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sck_host_oe_n,
  input wire logic sck_dev_oe_n,
  input wire logic sdo_oe_n,
  input wire logic sck,
  input wire logic sdo
);
  logic sck_reg;
  logic [5:0] nrise_reg;
  logic [5:0] nrise_next;
  logic rise;
  logic fall;
  default clocking @(posedge osc_clk_in); endclocking
  default disable iff (srst_in);
  // edges of the resolved clock pin, one cycle late
  assign rise = sck && !sck_reg;
  assign fall = !sck && sck_reg;
  // rises per frame; select high or the closing fall restarts the count
  always_comb
  begin
    nrise_next = nrise_reg;
    if (cs_n || (fall && nrise_reg == 6'h20))
      nrise_next = 6'h00;
    else if (rise)
      nrise_next = nrise_reg + 6'h01;
  end
  always_ff @(posedge osc_clk_in)
  begin
    sck_reg <= sck;
    nrise_reg <= srst_in ? 6'h00 : nrise_next;
  end
  chk_sdo_release: assert property ($rose(cs_n) |-> ##[1:5] sdo_oe_n)
    else $error("data out still driven while deselected");
  chk_sel_flag: assert property ($fell(cs_n) && sck |-> ##[1:5] !sdo_oe_n)
    else $error("no done flag after select fall");
  chk_sel_clock: assert property ($fell(cs_n) && sck |-> ##[1:5] !sck_dev_oe_n)
    else $error("device did not take the clock pin");
  chk_clock_starts: assert property ($fell(cs_n) && sck |-> ##[2:200] (rise || cs_n))
    else $error("device clock never started");
  chk_int_half: assert property (rise && !sck_dev_oe_n && nrise_reg < 6'h1F
    |-> sck [*8] ##1 (!sck || cs_n))
    else $error("internal clock high phase not eight cycles");
  chk_data_on_fall: assert property (rise && nrise_reg < 6'h1F
    |-> ##1 $stable(sdo) [*4])
    else $error("data out moved while clock high");
  chk_sdi_hold: assert property (rise |-> $stable(sdi))
    else $error("data in moved at clock rise");
  chk_int_end_conv: assert property (rise && nrise_reg == 6'h1F && !sck_dev_oe_n
    |-> ##[0:8] (sck && sdo) [*8])
    else $error("clock and data out not high after last rise");
  chk_ext_end_flag: assert property (fall && nrise_reg == 6'h20 && sck_dev_oe_n
    |-> ##[0:5] sdo [*8])
    else $error("busy flag missing after last fall");
  chk_ext_select: assert property (!sck_host_oe_n |-> !cs_n)
    else $error("select high while host drives the clock");
  // main scenarios reached
  cover property (rise && nrise_reg == 6'h1F && !sck_dev_oe_n);
  cover property (fall && nrise_reg == 6'h20);
  cover property ($rose(cs_n) && nrise_reg > 6'h00 && nrise_reg < 6'h1F);
endmodule

// ==== testbench/tb_top.sv ====
// bench: both link ends joined; reads, aborts and both clock modes
`timescale 1ns/10ps
module tb_top;
  import astm_pkg::*;
  localparam int POR_SIM = 20;
  localparam int LIMIT = 40000;
  logic clk_in = 1'h0;
  logic osc_clk = 1'h0;
  logic srst_in = 1'h1;
  logic ext_mode_in = 1'h0;
  logic start_in = 1'h0;
  logic abort_in = 1'h0;
  logic [7:0] chan_in = 8'h00;
  logic [7:0] cfg_in = 8'h00;
  logic [31:0] conv_result_in = 32'hF0C3_A55A;
  logic busy_out, result_valid_out, conv_start_out, eoc_n_out, ext_mode_out;
  logic [31:0] result_out;
  logic [7:0] chan_out, cfg_out;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  astm_link_if link();
  // short power-on and conversion counts keep the run brief
  astm_dev #(.POR_CYC(POR_SIM), .CONV_CYC(40)) astm_dev_i (.osc_clk_in(osc_clk),
    .srst_in(srst_in), .link(link), .conv_result_in(conv_result_in),
    .conv_start_out(conv_start_out), .eoc_n_out(eoc_n_out), .ext_mode_out(ext_mode_out),
    .chan_out(chan_out), .cfg_out(cfg_out));
  astm_host astm_host_i (.clk_in(clk_in), .srst_in(srst_in), .link(link),
    .ext_mode_in(ext_mode_in), .start_in(start_in), .abort_in(abort_in), .chan_in(chan_in),
    .cfg_in(cfg_in), .busy_out(busy_out), .result_valid_out(result_valid_out),
    .result_out(result_out));
  astm_link_monitor astm_link_monitor_i (.osc_clk_in(osc_clk), .srst_in(srst_in),
    .cs_n(link.cs_n), .sdi(link.sdi), .sck_host_oe_n(link.sck_host_oe_n),
    .sck_dev_oe_n(link.sck_dev_oe_n), .sdo_oe_n(link.sdo_oe_n), .sck(link.sck),
    .sdo(link.sdo));
  // host clock
  always #25 clk_in = ~clk_in;
  // link clock, offset so its edges never meet the host clock's
  initial
  begin
    #7;
    forever #40 osc_clk = ~osc_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // reset both ends; the clock pin level picks the mode at power-on end
  task automatic do_reset(input logic ext);
    int cnt;
    cnt = 0;
    srst_in = 1'h1;
    ext_mode_in = ext;
    repeat (10) @(negedge clk_in);
    srst_in = 1'h0;
    check(32'({cfg_out, chan_out}), 32'({CFG_RST, CHAN_RST}));
    check(32'(eoc_n_out), 32'h1);
    // sample between link clock edges, where the pulse has settled
    while (conv_start_out !== 1'h1)
    begin
      @(negedge osc_clk);
      cnt++;
    end
    check(32'(cnt >= POR_SIM && cnt <= POR_SIM + 6), 32'h1);
    check(32'(ext_mode_out), 32'(ext));
  endtask
  // full read; the done flag replaces the top result bit
  task automatic read(input logic [7:0] ch, input logic [7:0] cf);
    @(negedge clk_in);
    chan_in = ch;
    cfg_in = cf;
    start_in = 1'h1;
    @(negedge clk_in);
    start_in = 1'h0;
    check(32'(busy_out), 32'h1);
    while (result_valid_out !== 1'h1)
      @(negedge clk_in);
    check(result_out, {1'h0, conv_result_in[30:0]});
    check(32'(busy_out), 32'h0);
    repeat (20) @(negedge clk_in);
    check(32'({cfg_out, chan_out}), 32'({cf, ch}));
  endtask
  // raise select after n device clock falls
  task automatic abort_after(input int n, input logic [7:0] ch, input logic [7:0] cf,
    input logic [15:0] exp);
    int cnt;
    cnt = 0;
    @(negedge clk_in);
    chan_in = ch;
    cfg_in = cf;
    start_in = 1'h1;
    @(negedge clk_in);
    start_in = 1'h0;
    @(posedge link.sck);
    repeat (n) @(negedge link.sck);
    @(negedge clk_in);
    abort_in = 1'h1;
    @(posedge link.cs_n);
    while (conv_start_out !== 1'h1)
    begin
      @(negedge osc_clk);
      cnt++;
    end
    check(32'(cnt <= 6), 32'h1);
    check(32'(eoc_n_out), 32'h1);
    @(negedge clk_in);
    abort_in = 1'h0;
    repeat (4) @(negedge clk_in);
    check(32'({cfg_out, chan_out}), 32'(exp));
  endtask
  // hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    do_reset(1'h0);
    read(8'hA5, 8'h3C);
    // second read lands while the device converts
    read(8'h5A, 8'hC3);
    abort_after(4, 8'h11, 8'h22, 16'hC35A);
    abort_after(12, 8'h33, 8'h44, 16'hC333);
    abort_after(20, 8'h66, 8'h77, 16'h7766);
    read(8'h0F, 8'hF0);
    // second reset mid-run selects the external clock
    conv_result_in = 32'h6B1D_2E97;
    do_reset(1'h1);
    read(8'h9C, 8'h0F);
    read(8'h81, 8'hE7);
    report_and_stop();
  end
endmodule
